//--- hw/uartc_core.sv
// Purpose: Serial transceiver core with legacy and extended FIFO modes.
// Assumes: Synchronous host port; 16x baud tick made from baud_div.
// Notes:   Overview of rules below.
`timescale 1ns/100ps
module uartc_core #(
  parameter int FIFO_DEPTH = uartc_pkg::FIFO_DEPTH
) (
  // Clock and resets
  input  wire logic                            clk,
  input  wire logic                            rst,
  input  wire logic                            soft_reset,
  // Host port
  input  wire uartc_pkg::uartc_host_req_s      host_req,
  output      logic [uartc_pkg::DATA_W-1:0]    host_rdata,
  // Line configuration
  input  wire logic [uartc_pkg::DIV_W-1:0]     baud_div,
  input  wire logic                            tx_enable,
  // Serial pins
  input  wire logic                            rx_pin,
  output      logic                            tx_pin,
  output      logic                            rts_n,
  // Status
  output      uartc_pkg::uartc_status_s        status
);
  localparam int CW = $clog2(FIFO_DEPTH+1);
  localparam int DW = uartc_pkg::DATA_W;
  localparam int FW = uartc_pkg::FRAME_W;
  typedef logic [uartc_pkg::CNT_W-1:0] uartc_cnt_t;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_SHIFT = 2'b01
  } uartc_tx_e;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_BITS  = 2'b10
  } uartc_rx_e;

  typedef struct packed {
    logic [7:0]               mctl;
    logic [7:0]               fctl;
    logic [7:0]               lcr;
    logic [7:0]               txlvl;
    logic [7:0]               rxlvl;
    logic [7:0]               flwh;
    logic [7:0]               flwl;
    logic                     ext_q;
    logic                     fen_q;
    logic [DW-1:0]            rdata;
    logic [uartc_pkg::DIV_W-1:0] baud_cnt;
    uartc_tx_e                tx_st;
    logic [FW-1:0]            tx_frame;
    logic [3:0]               tx_bits;
    logic [3:0]               tx_os;
    logic                     tx_line;
    logic                     tx_pin;
    logic                     rts_n;
    logic [2:0]               rx_sync;
    logic                     rx_prev;
    uartc_rx_e                rx_st;
    logic [FW-1:0]            rx_shift;
    logic [3:0]               rx_bits;
    logic [3:0]               rx_os;
    logic                     rx_push;
    logic [FW-1:0]            rx_word;
    uartc_pkg::uartc_status_s st;
  } uartc_core_s;

  uartc_core_s s_q;
  uartc_core_s s_d;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] data_len(input logic [7:0] lcr);
    data_len = 4'(uartc_pkg::MIN_LEN) + {2'b00, lcr[1:0]};
  endfunction

  function automatic logic [3:0] frame_len(input logic [7:0] lcr);
    frame_len = 4'h1 + data_len(lcr) + {3'b000, lcr[uartc_pkg::LCR_PAR]}
              + 4'h1 + {3'b000, lcr[uartc_pkg::LCR_STOP]};
  endfunction

  function automatic logic par_bit(input logic [DW-1:0] d,
                                   input logic [7:0]    lcr);
    logic p;
    p = 1'b0;
    for (int i = 0; i < DW; i++) begin
      if (4'(i) < data_len(lcr)) begin
        p = p ^ d[i];
      end
    end
    par_bit = lcr[uartc_pkg::LCR_EVEN] ? p : ~p;
  endfunction

  function automatic logic [FW-1:0] build_frame(input logic [DW-1:0] d,
                                                input logic [7:0]    lcr);
    logic [FW-1:0] f;
    f = '1;
    f[0] = 1'b0;
    for (int i = 0; i < DW; i++) begin
      if (4'(i) < data_len(lcr)) begin
        f[i+1] = d[i];
      end
    end
    if (lcr[uartc_pkg::LCR_PAR]) begin
      f[data_len(lcr) + 4'h1] = par_bit(d, lcr);
    end
    build_frame = f;
  endfunction

  // ----------------------------------------------------------------
  // FIFOs
  // ----------------------------------------------------------------
  logic          tx_in_ready;
  logic          tx_out_valid;
  logic [DW-1:0] tx_out_data;
  logic          tx_pop;
  logic [CW-1:0] tx_count;
  logic          tx_push;
  logic          rx_in_ready;
  logic          rx_out_valid;
  logic [DW-1:0] rx_out_data;
  logic          rx_pop;
  logic [CW-1:0] rx_count;
  logic          rx_accept;
  logic          flush;
  logic          ext_now;
  logic [CW-1:0] cap;
  logic          acc;
  logic          tick;
  logic          rx_in;
  logic [7:0]    rx_trig_lvl;
  logic [7:0]    tx_trig_lvl;
  logic [DW-1:0] rx_data;
  logic [3:0]    rx_len;

  uartc_fifo #(.W(DW), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .clk       (clk),
    .rst       (rst || soft_reset),
    .flush     (flush),
    .in_valid  (tx_push),
    .in_data   (host_req.wdata),
    .in_ready  (tx_in_ready),
    .out_valid (tx_out_valid),
    .out_data  (tx_out_data),
    .out_ready (tx_pop),
    .count     (tx_count)
  );

  uartc_fifo #(.W(DW), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .clk       (clk),
    .rst       (rst || soft_reset),
    .flush     (flush),
    .in_valid  (rx_accept),
    .in_data   (rx_data),
    .in_ready  (rx_in_ready),
    .out_valid (rx_out_valid),
    .out_data  (rx_out_data),
    .out_ready (rx_pop),
    .count     (rx_count)
  );

  // ----------------------------------------------------------------
  // Mode, capacity and triggers
  // ----------------------------------------------------------------
  always_comb begin
    ext_now = (s_q.txlvl | s_q.rxlvl | s_q.flwh | s_q.flwl) != '0;
    // Size change, either by enable or by mode, empties both FIFOs
    flush = (ext_now != s_q.ext_q) ||
            (s_q.fctl[uartc_pkg::FC_EN] != s_q.fen_q);
    if (!s_q.fctl[uartc_pkg::FC_EN]) begin
      cap = CW'(1);
    end else if (ext_now) begin
      cap = CW'(FIFO_DEPTH);
    end else begin
      cap = CW'(uartc_pkg::LEGACY_DEPTH);
    end
    if (ext_now) begin
      // Zero in one register while another enables the mode acts as 1
      rx_trig_lvl = (s_q.rxlvl == '0) ? 8'h01 : s_q.rxlvl;
      tx_trig_lvl = (s_q.txlvl == '0) ? 8'h01 : s_q.txlvl;
    end else begin
      rx_trig_lvl = uartc_pkg::RX_TRIG_LEG[s_q.fctl[uartc_pkg::FC_RX_LO+:2]];
      tx_trig_lvl = uartc_pkg::TX_TRIG_LEG[s_q.fctl[uartc_pkg::FC_TX_LO+:2]];
    end
  end

  // ----------------------------------------------------------------
  // Datapath strobes
  // ----------------------------------------------------------------
  always_comb begin
    acc     = !host_req.cs_n;
    tx_push = acc && host_req.wr && host_req.addr == uartc_pkg::A_DATA &&
              tx_in_ready && tx_count < cap;
    rx_pop  = acc && host_req.rd && host_req.addr == uartc_pkg::A_DATA;
    tx_pop  = s_q.tx_st == TX_IDLE && tx_enable && tx_out_valid && !flush;
    tick    = s_q.baud_cnt == '0;
    // Loopback takes the transmit stream in place of the pin
    rx_in   = s_q.mctl[uartc_pkg::MC_LOOP] ? s_q.tx_line
                                           : s_q.rx_sync[2];
    rx_len  = data_len(s_q.lcr);
    rx_data = s_q.rx_word[DW:1];
    for (int i = 0; i < DW; i++) begin
      if (4'(i) >= rx_len) begin
        rx_data[i] = 1'b0;
      end
    end
    rx_accept = s_q.rx_push && rx_in_ready && rx_count < cap;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.ext_q   = ext_now;
    s_d.fen_q   = s_q.fctl[uartc_pkg::FC_EN];
    s_d.rx_push = 1'b0;

    // Register writes
    if (acc && host_req.wr) begin
      case (host_req.addr)
        uartc_pkg::A_MCTL:  s_d.mctl  = host_req.wdata;
        uartc_pkg::A_FCTL:  s_d.fctl  = host_req.wdata;
        uartc_pkg::A_LCR:   s_d.lcr   = host_req.wdata;
        uartc_pkg::A_TXLVL: s_d.txlvl = host_req.wdata;
        uartc_pkg::A_RXLVL: s_d.rxlvl = host_req.wdata;
        uartc_pkg::A_FLWH:  s_d.flwh  = host_req.wdata;
        uartc_pkg::A_FLWL:  s_d.flwl  = host_req.wdata;
        default:            s_d.mctl  = s_q.mctl;
      endcase
    end

    // Register reads, unmapped selects read zero
    if (acc && host_req.rd) begin
      case (host_req.addr)
        uartc_pkg::A_DATA:  s_d.rdata = rx_out_valid ? rx_out_data : '0;
        uartc_pkg::A_MCTL:  s_d.rdata = s_q.mctl;
        uartc_pkg::A_FCTL:  s_d.rdata = s_q.fctl;
        uartc_pkg::A_LCR:   s_d.rdata = s_q.lcr;
        uartc_pkg::A_TXLVL: s_d.rdata = s_q.txlvl;
        uartc_pkg::A_RXLVL: s_d.rdata = s_q.rxlvl;
        uartc_pkg::A_FLWH:  s_d.rdata = s_q.flwh;
        uartc_pkg::A_FLWL:  s_d.rdata = s_q.flwl;
        default:            s_d.rdata = '0;
      endcase
    end

    // 16x tick; 80 MHz with divisor 1 gives 5 Mbit/s
    s_d.baud_cnt = tick ? ((baud_div == '0) ? '0 : baud_div - 16'h0001)
                        : s_q.baud_cnt - 16'h0001;

    // Transmitter
    case (s_q.tx_st)
      TX_IDLE: begin
        s_d.tx_line = 1'b1;
        if (tx_pop) begin
          s_d.tx_frame = build_frame(tx_out_data, s_q.lcr);
          s_d.tx_bits  = frame_len(s_q.lcr);
          s_d.tx_os    = '0;
          s_d.tx_st    = TX_SHIFT;
        end
      end
      TX_SHIFT: begin
        s_d.tx_line = s_q.tx_frame[0];
        if (tick) begin
          s_d.tx_os = s_q.tx_os + 4'h1;
          if (s_q.tx_os == 4'(uartc_pkg::OVERSAMPLE-1)) begin
            s_d.tx_frame = {1'b1, s_q.tx_frame[FW-1:1]};
            s_d.tx_bits  = s_q.tx_bits - 4'h1;
            if (s_q.tx_bits == 4'h1) begin
              s_d.tx_st = TX_IDLE;
            end
          end
        end
      end
      default: s_d.tx_st = TX_IDLE;
    endcase
    // Pin held high when idle, disabled or looped back
    s_d.tx_pin = (s_q.mctl[uartc_pkg::MC_LOOP] || !tx_enable) ? 1'b1
                 : s_d.tx_line;
    s_d.rts_n  = !s_q.mctl[uartc_pkg::MC_RTS];

    // Receiver, pin passes three flops, second and third must agree
    s_d.rx_sync = {s_q.rx_sync[1:0], rx_pin};
    if (s_q.rx_sync[2] == s_q.rx_sync[1] || s_q.mctl[uartc_pkg::MC_LOOP]) begin
      s_d.rx_prev = rx_in;
    end
    case (s_q.rx_st)
      RX_IDLE: begin
        if (s_q.rx_prev && !rx_in && (s_q.rx_sync[2] == s_q.rx_sync[1] ||
            s_q.mctl[uartc_pkg::MC_LOOP])) begin
          s_d.rx_os = '0;
          s_d.rx_st = RX_START;
        end
      end
      RX_START: begin
        if (tick) begin
          s_d.rx_os = s_q.rx_os + 4'h1;
          if (s_q.rx_os == 4'(uartc_pkg::MID_SAMPLE)) begin
            // A glitch shorter than half a bit is not a start
            s_d.rx_st    = rx_in ? RX_IDLE : RX_BITS;
            s_d.rx_os    = '0;
            s_d.rx_shift = '1;
            s_d.rx_bits  = frame_len(s_q.lcr) - 4'h1 -
                           {3'b000, s_q.lcr[uartc_pkg::LCR_STOP]};
          end
        end
      end
      RX_BITS: begin
        if (tick) begin
          s_d.rx_os = s_q.rx_os + 4'h1;
          if (s_q.rx_os == 4'(uartc_pkg::OVERSAMPLE-1)) begin
            s_d.rx_shift = {rx_in, s_q.rx_shift[FW-1:1]};
            s_d.rx_bits  = s_q.rx_bits - 4'h1;
            if (s_q.rx_bits == 4'h1) begin
              // Align so bit 0 is the start slot, data from bit 1
              s_d.rx_word = s_d.rx_shift >> (4'(FW) - frame_len(s_q.lcr) +
                            {3'b000, s_q.lcr[uartc_pkg::LCR_STOP]});
              s_d.rx_push = 1'b1;
              s_d.rx_st   = RX_IDLE;
            end
          end
        end
      end
      default: s_d.rx_st = RX_IDLE;
    endcase

    // Status, a new error wins over the clear by a data read
    if (rx_pop) begin
      s_d.st.parity_err = 1'b0;
      s_d.st.frame_err  = 1'b0;
      s_d.st.overrun    = 1'b0;
    end
    if (s_q.rx_push) begin
      if (s_q.lcr[uartc_pkg::LCR_PAR] &&
          s_q.rx_word[rx_len + 4'h1] != par_bit(rx_data, s_q.lcr)) begin
        s_d.st.parity_err = 1'b1;
      end
      if (!s_q.rx_word[rx_len + 4'h1 +
                       {3'b000, s_q.lcr[uartc_pkg::LCR_PAR]}]) begin
        s_d.st.frame_err = 1'b1;
      end
      if (!rx_accept) begin
        s_d.st.overrun = 1'b1;
      end
    end
    s_d.st.ext_mode = ext_now;
    s_d.st.tx_level = uartc_cnt_t'(tx_count);
    s_d.st.rx_level = uartc_cnt_t'(rx_count);
    s_d.st.rx_trig  = CW'(rx_trig_lvl) <= rx_count;
    s_d.st.tx_trig  = CW'(tx_trig_lvl) <= cap - tx_count;
    s_d.st.tx_full  = tx_count >= cap;
  end

  always_ff @(posedge clk) begin
    if (rst || soft_reset) begin
      s_q         <= '0;
      s_q.tx_line <= 1'b1;
      s_q.tx_pin  <= 1'b1;
      s_q.rts_n   <= 1'b1;
      s_q.rx_sync <= 3'b111;
      s_q.rx_prev <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign host_rdata = s_q.rdata;
  assign tx_pin     = s_q.tx_pin;
  assign rts_n      = s_q.rts_n;
  assign status     = s_q.st;

endmodule

//--- hw/uartc_fifo.sv
// Purpose: Character FIFO with a registered read port.
// Assumes: Single clock; flush empties it in one cycle.
// Notes:   count includes the word held in the output register.
`timescale 1ns/100ps
module uartc_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 128
) (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       flush,
  // Write side
  input  wire logic                       in_valid,
  input  wire logic [W-1:0]               in_data,
  output      logic                       in_ready,
  // Read side
  output      logic                       out_valid,
  output      logic [W-1:0]               out_data,
  input  wire logic                       out_ready,
  // Occupancy
  output      logic [$clog2(DEPTH+1)-1:0] count
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wr_ptr;
    logic [PW-1:0]           rd_ptr;
    logic [CW-1:0]           cnt;
    logic                    ovalid;
    logic [W-1:0]            odata;
  } uartc_fifo_s;

  uartc_fifo_s s_q;
  uartc_fifo_s s_d;
  logic        push;
  logic        load;

  assign in_ready  = (s_q.cnt < CW'(DEPTH));
  assign out_valid = s_q.ovalid;
  assign out_data  = s_q.odata;
  assign count     = s_q.cnt + CW'(s_q.ovalid);

  always_comb begin
    s_d  = s_q;
    push = in_valid && in_ready;
    load = (!s_q.ovalid || out_ready) && (s_q.cnt != '0);
    if (out_ready && s_q.ovalid) begin
      s_d.ovalid = 1'b0;
    end
    // Output word comes from a register, never straight from memory
    if (load) begin
      s_d.odata  = s_q.mem[s_q.rd_ptr];
      s_d.ovalid = 1'b1;
      s_d.rd_ptr = s_q.rd_ptr + PW'(1);
    end
    if (push) begin
      s_d.mem[s_q.wr_ptr] = in_data;
      s_d.wr_ptr          = s_q.wr_ptr + PW'(1);
    end
    s_d.cnt = s_q.cnt + CW'(push) - CW'(load);
    if (flush) begin
      s_d.wr_ptr = '0;
      s_d.rd_ptr = '0;
      s_d.cnt    = '0;
      s_d.ovalid = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

//--- include/uartc_pkg.sv
// Purpose: Shared constants and carriers for the serial core.
// Assumes: 8-bit characters at most, 16x oversampling.
// Notes:   Host access selects one of the core's registers by a small code.
package uartc_pkg;

  // ----------------------------------------------------------------
  // Sizes and timing
  // ----------------------------------------------------------------
  localparam int DATA_W       = 8;
  localparam int FIFO_DEPTH   = 128;
  localparam int LEGACY_DEPTH = 32;
  localparam int CNT_W        = 8;
  localparam int OVERSAMPLE   = 16;
  localparam int MID_SAMPLE   = 7;
  localparam int FRAME_W      = 12;
  localparam int DIV_W        = 16;
  localparam int CLK_HZ       = 40_000_000;
  localparam int EXT_CLK_HZ   = 80_000_000;
  localparam int MAX_BIT_RATE = 5_000_000;
  // Fastest bit rate reachable on this clock with 16x oversampling
  localparam int MAX_BIT_RATE_HERE = CLK_HZ / OVERSAMPLE;

  // ----------------------------------------------------------------
  // Register selects on the host port
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    A_DATA   = 4'h0,
    A_MCTL   = 4'h1,
    A_FCTL   = 4'h2,
    A_LCR    = 4'h3,
    A_TXLVL  = 4'h4,
    A_RXLVL  = 4'h5,
    A_FLWH   = 4'h6,
    A_FLWL   = 4'h7
  } uartc_addr_e;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int MC_RTS     = 1;
  localparam int MC_LOOP    = 4;
  localparam int FC_EN      = 0;
  localparam int FC_TX_LO   = 4;
  localparam int FC_RX_LO   = 6;
  localparam int LCR_STOP   = 2;
  localparam int LCR_PAR    = 3;
  localparam int LCR_EVEN   = 4;
  localparam int MIN_LEN    = 5;
  localparam logic [7:0] REG_RST = 8'h00;

  // Legacy trigger levels, index is the two-bit field
  localparam logic [3:0][7:0] RX_TRIG_LEG = {8'h1C, 8'h18, 8'h10, 8'h08};
  localparam logic [3:0][7:0] TX_TRIG_LEG = {8'h1E, 8'h18, 8'h08, 8'h10};

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              cs_n;
    logic              wr;
    logic              rd;
    uartc_addr_e       addr;
    logic [DATA_W-1:0] wdata;
  } uartc_host_req_s;

  typedef struct packed {
    logic             ext_mode;
    logic [CNT_W-1:0] tx_level;
    logic [CNT_W-1:0] rx_level;
    logic             tx_trig;
    logic             rx_trig;
    logic             parity_err;
    logic             frame_err;
    logic             overrun;
    logic             tx_full;
  } uartc_status_s;

endpackage

//--- tb/uartc_chk.sv
// Purpose: Port checker for the serial core.
// Assumes: Status and pins settle within three clocks of a write.
// Notes:   Mirrors control bits from host writes with cs_n low.
`timescale 1ns/100ps
module uartc_chk (
  // Clock and resets
  input wire logic                         clk,
  input wire logic                         rst,
  input wire logic                         soft_reset,
  // Host side
  input wire uartc_pkg::uartc_host_req_s   host_req,
  input wire logic [uartc_pkg::DATA_W-1:0] host_rdata,
  // Line side
  input wire logic                         tx_enable,
  input wire logic                         tx_pin,
  input wire logic                         rts_n,
  input wire uartc_pkg::uartc_status_s     status
);
  logic       wr_ok;
  logic       mc_wr;
  logic       lvl_wr;
  logic [1:0] quiet_q;
  logic       rts_exp_q;
  logic       loop_q;
  logic [3:0] lvl_nz_q;
  assign wr_ok  = !host_req.cs_n && host_req.wr;
  assign mc_wr  = wr_ok && host_req.addr == uartc_pkg::A_MCTL;
  assign lvl_wr = wr_ok && host_req.addr[3:2] == 2'h1;
  // Outputs are trusted only after three quiet edges
  always_ff @(posedge clk) begin
    if (rst || soft_reset) begin
      quiet_q   <= 2'h0;
      rts_exp_q <= 1'b1;
      loop_q    <= 1'b0;
      lvl_nz_q  <= 4'h0;
    end else begin
      if (mc_wr || lvl_wr) begin
        quiet_q <= 2'h0;
      end else if (quiet_q != 2'h3) begin
        quiet_q <= quiet_q + 2'h1;
      end
      if (mc_wr) begin
        rts_exp_q <= !host_req.wdata[uartc_pkg::MC_RTS];
        loop_q    <= host_req.wdata[uartc_pkg::MC_LOOP];
      end
      if (lvl_wr) begin
        lvl_nz_q[host_req.addr[1:0]] <= |host_req.wdata;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || soft_reset);
  sequence start_bit_s;
    (!tx_pin) [*8];
  endsequence
  reset_idle_a: assert property (
    $fell(rst) |-> rts_n && tx_pin) else $error("idle levels wrong");
  reset_state_a: assert property (
    $fell(rst) |-> status == '0 && host_rdata == '0)
    else $error("state not cleared by reset");
  rts_follow_a: assert property (
    quiet_q == 2'h3 |-> rts_n == rts_exp_q) else $error("rts_n wrong");
  loop_quiet_a: assert property (
    loop_q && quiet_q == 2'h3 |-> tx_pin) else $error("tx in loopback");
  tx_disabled_a: assert property (
    (!tx_enable) [*2] |-> tx_pin) else $error("tx while disabled");
  start_len_a: assert property (
    $fell(tx_pin) |-> start_bit_s) else $error("short start bit");
  ext_mode_a: assert property (
    quiet_q == 2'h3 |-> status.ext_mode == (|lvl_nz_q))
    else $error("ext_mode wrong");
  flush_a: assert property (
    $changed(status.ext_mode) |-> ##[0:2]
      (status.tx_level == 8'h00 && status.rx_level == 8'h00))
    else $error("no flush on size change");
  level_cap_a: assert property (
    status.tx_level <= 8'h80 && status.rx_level <= 8'h80)
    else $error("fifo level above depth");
  cs_ignore_a: assert property (
    host_req.cs_n |=> $stable(host_rdata)) else $error("read without cs");
endmodule
bind uartc_core uartc_chk i_uartc_chk (
  .clk(clk), .rst(rst), .soft_reset(soft_reset), .host_req(host_req),
  .host_rdata(host_rdata), .tx_enable(tx_enable), .tx_pin(tx_pin),
  .rts_n(rts_n), .status(status)
);

//--- tb/uartc_core_test.sv
// Purpose: Self-checking bench for the serial core.
// Assumes: baud_div of 1, so one bit lasts 16 clocks.
// Notes:   Line set to 8 data bits, even parity, one stop bit.
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin \
  tests_run++; \
  if ((got) !== (ex)) begin \
    num_errors++; \
    $display("BAD %s exp %0h got %0h", nm, ex, got); \
  end \
end
module uartc_core_test;
  logic                       clk = 1'b0;
  logic                       rst = 1'b1;
  logic                       soft_reset = 1'b0;
  logic                       tx_enable = 1'b0;
  uartc_pkg::uartc_host_req_s req;
  logic [7:0]                 rdata;
  logic                       rx_pin;
  logic                       tx_pin;
  logic                       rts_n;
  uartc_pkg::uartc_status_s   status;
  int                         num_errors = 0;
  int                         tests_run = 0;
  always #12.5 clk = ~clk;
  uartc_core i_uartc_core (.clk(clk), .rst(rst), .soft_reset(soft_reset),
    .host_req(req), .host_rdata(rdata), .baud_div(16'h0001),
    .tx_enable(tx_enable), .rx_pin(rx_pin), .tx_pin(tx_pin),
    .rts_n(rts_n), .status(status));
  uartc_remote i_uartc_remote (.clk(clk), .rx_line(rx_pin));
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Strobe drops for one edge so back-to-back calls stay clean
  task automatic acc(input logic w, input uartc_pkg::uartc_addr_e a,
                     input logic [7:0] d, input logic sel_n = 1'b0);
    req.cs_n = sel_n;
    req.wr = w;
    req.rd = !w;
    req.addr = a;
    req.wdata = d;
    step(1);
    req.cs_n = 1'b1;
    req.wr = 1'b0;
    req.rd = 1'b0;
    step(1);
  endtask
  task automatic report_and_stop;
    if (num_errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic s_reset;
    `CHK("rts idle", 1'b1, rts_n)
    `CHK("tx idle", 1'b1, tx_pin)
    acc(1, uartc_pkg::A_MCTL, 8'h02);
    `CHK("rts on", 1'b0, rts_n)
    acc(1, uartc_pkg::A_MCTL, 8'h00, 1'b1);
    `CHK("rts unselected", 1'b0, rts_n)
    acc(1, uartc_pkg::A_FLWL, 8'h01);
    step(4);
    `CHK("ext on", 1'b1, status.ext_mode)
    soft_reset = 1'b1;
    step(1);
    soft_reset = 1'b0;
    `CHK("rts soft", 1'b1, rts_n)
    `CHK("status soft", '0, status)
  endtask
  task automatic fill(input int n);
    for (int i = 0; i < n; i++) acc(1, uartc_pkg::A_DATA, 8'(i));
    step(4);
  endtask
  task automatic s_fifo;
    acc(1, uartc_pkg::A_FCTL, 8'h01);
    acc(1, uartc_pkg::A_LCR, 8'h1B);
    fill(40);
    `CHK("legacy cap", 8'h20, status.tx_level)
    `CHK("tx full", 1'b1, status.tx_full)
    `CHK("tx trig leg", 1'b0, status.tx_trig)
    acc(1, uartc_pkg::A_TXLVL, 8'h05);
    step(4);
    `CHK("flush to ext", 8'h00, status.tx_level)
    fill(40);
    `CHK("ext depth", 8'h28, status.tx_level)
    `CHK("tx trig ext", 1'b1, status.tx_trig)
    for (int i = 4; i < 8; i++) begin
      acc(1, uartc_pkg::uartc_addr_e'(i), 8'h00);
      step(4);
      `CHK("ext off", 1'b0, status.ext_mode)
      `CHK("flush to legacy", 8'h00, status.tx_level)
      acc(1, uartc_pkg::uartc_addr_e'(i), 8'h80);
      step(4);
      `CHK("ext each", 1'b1, status.ext_mode)
      acc(1, uartc_pkg::uartc_addr_e'(i), 8'h00);
    end
  endtask
  task automatic s_tx;
    logic [10:0] f;
    int          n;
    f = {1'b1, ^8'h07, 8'h07, 1'b0};
    n = 0;
    tx_enable = 1'b1;
    acc(1, uartc_pkg::A_DATA, 8'h07);
    while (tx_pin !== 1'b0 && n < 200) begin
      step(1);
      n++;
    end
    if (n == 200) begin
      num_errors++;
      report_and_stop;
    end
    step(8);
    for (int i = 0; i < 11; i++) begin
      `CHK("tx bit", f[i], tx_pin)
      step(16);
    end
    `CHK("tx after frame", 1'b1, tx_pin)
  endtask
  task automatic rx_chk(input logic [7:0] d, input logic par,
                        input logic stp, input logic [1:0] errs);
    i_uartc_remote.send(d, par, stp);
    step(4);
    `CHK("errors", errs, {status.parity_err, status.frame_err})
    acc(0, uartc_pkg::A_DATA, 8'h00);
    if (errs == 2'h0) `CHK("rx data", d, rdata)
  endtask
  task automatic s_rx;
    rx_chk(8'hC5, ^8'hC5, 1'b1, 2'h0);
    rx_chk(8'h3C, ~^8'h3C, 1'b1, 2'h2);
    rx_chk(8'h81, ^8'h81, 1'b0, 2'h1);
  endtask
  task automatic s_loop;
    acc(1, uartc_pkg::A_MCTL, 8'h10);
    i_uartc_remote.hold(1'b0);
    acc(1, uartc_pkg::A_DATA, 8'hA3);
    for (int i = 0; i < 12; i++) begin
      `CHK("tx in loop", 1'b1, tx_pin)
      step(16);
    end
    acc(0, uartc_pkg::A_DATA, 8'h00);
    `CHK("loop data", 8'hA3, rdata)
    i_uartc_remote.hold(1'b1);
    acc(1, uartc_pkg::A_MCTL, 8'h00);
  endtask
  initial begin
    req = '0;
    req.cs_n = 1'b1;
    step(4);
    rst = 1'b0;
    s_reset;
    s_fifo;
    s_tx;
    s_rx;
    s_loop;
    report_and_stop;
  end
endmodule

//--- tb/uartc_remote.sv
// Purpose: Remote serial sender driving the core's receive pin.
// Assumes: Caller enters just after a clock edge.
// Notes:   Parity and stop values are given by the caller.
`timescale 1ns/100ps
module uartc_remote #(
  parameter int BIT_CYC = 16
) (
  // Clock
  input wire logic clk,
  // Serial line
  output     logic rx_line
);
  initial rx_line = 1'b1;
  task automatic send(input logic [7:0] d, input logic par,
                      input logic stp);
    logic [10:0] f;
    f = {stp, par, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rx_line = f[i];
      repeat (BIT_CYC) @(posedge clk);
      #1;
    end
    rx_line = 1'b1;
  endtask
  task automatic hold(input logic v);
    rx_line = v;
  endtask
endmodule
